// ---- atf_tx_framer.sv ----
// transmit framer: cell input, cell store, command bytes, scrambler, 4b5b, NRZI
`timescale 1ns/1ps
`default_nettype none
module atf_tx_framer #(
	parameter int NPORT = atf_pkg::NUM_PORTS
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// static straps
	input wire logic [1:0] mode_sel_in,
	input wire logic rate_double_in,
	// shared cell bus, 16 or 8 bits
	input wire logic [15:0] bus_data_in,
	input wire logic [1:0] bus_port_in,
	input wire logic bus_valid_in,
	output wire logic bus_ready_out,
	// nibble path interfaces
	input wire logic [4*NPORT-1:0] nib_data_in,
	input wire logic [NPORT-1:0] nib_valid_in,
	output wire logic [NPORT-1:0] nib_ready_out,
	// timing marker insert and status
	input wire logic [NPORT-1:0] marker_sync_in,
	output wire logic [NPORT-1:0] tx_led_out,
	// line side
	atf_line_if.dev line
);
	import atf_pkg::*;

	if (NPORT < 1 || NPORT > 4) begin : g_bad_nport
		$error("NPORT must be 1 to 4");
	end

	// ****************************************
	// shared bit tick
	// ****************************************
	logic div_reg;
	logic div_next;
	logic tick;
	wire logic [NPORT-1:0] port_bus_rdy;

	always_comb begin
		div_next = ~div_reg;
		tick = rate_double_in | div_reg;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			div_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign line.bit_tick = tick;
	assign bus_ready_out = bus_valid_in && (32'(bus_port_in) < NPORT) && port_bus_rdy[bus_port_in];

	// ****************************************
	// per-port path
	// ****************************************
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic [7:0] hold_reg, hold_next;
		logic hold_v_reg, hold_v_next;
		logic [7:0] bf_mem [2];
		logic bf_wp_reg, bf_wp_next, bf_rp_reg, bf_rp_next;
		logic [1:0] bf_cnt_reg, bf_cnt_next;
		logic [7:0] st_mem [CELL_BYTES];
		logic [5:0] fill_reg, fill_next, idx_reg, idx_next;
		atf_tx_state_e st_reg, st_next;
		logic half_reg, half_next, mpend_reg, mpend_next, mact_reg, mact_next;
		logic first_reg, first_next, cmdx_reg, cmdx_next;
		logic [9:0] prng_reg, prng_next, age_reg, age_next;
		logic [4:0] sym_reg, sym_next;
		logic [2:0] bcnt_reg, bcnt_next;
		logic lvl_reg, lvl_next;
		logic sel, in_v, in_rdy, bf_push, bf_pop, store_rdy, load, brdy, nrdy;
		logic [7:0] in_d, cur;
		logic [3:0] nib;

		always_comb begin
			hold_next = hold_reg;
			hold_v_next = hold_v_reg;
			sel = bus_valid_in && (bus_port_in == 2'(p));
			in_rdy = (bf_cnt_reg != 2'h2);
			brdy = 1'b0;
			nrdy = 1'b0;
			case (mode_sel_in)
				MODE_NIBBLE: begin
					in_v = hold_v_reg & nib_valid_in[p];
					in_d = {hold_reg[3:0], nib_data_in[4*p +: 4]};
					nrdy = ~hold_v_reg | in_rdy;
					if (nib_valid_in[p] && !hold_v_reg) begin
						hold_next = {4'h0, nib_data_in[4*p +: 4]};
						hold_v_next = 1'b1;
					end else if (in_v && in_rdy) begin
						hold_v_next = 1'b0;
					end
				end
				MODE_BYTE_BUS: begin
					in_v = sel;
					in_d = bus_data_in[7:0];
					brdy = in_rdy;
				end
				default: begin
					in_v = hold_v_reg | sel;
					in_d = hold_v_reg ? hold_reg : bus_data_in[15:8];
					brdy = ~hold_v_reg & in_rdy;
					if (hold_v_reg) begin
						if (in_rdy) begin
							hold_v_next = 1'b0;
						end
					end else if (sel && in_rdy) begin
						hold_next = bus_data_in[7:0];
						hold_v_next = 1'b1;
					end
				end
			endcase

			// two-entry buffer into the cell store
			store_rdy = (st_reg == TX_IDLE) && (32'(fill_reg) != CELL_BYTES);
			bf_push = in_v & in_rdy;
			bf_pop = (bf_cnt_reg != 2'h0) & store_rdy;
			bf_cnt_next = 2'(bf_cnt_reg + {1'b0, bf_push} - {1'b0, bf_pop});
			bf_wp_next = bf_wp_reg ^ bf_push;
			bf_rp_next = bf_rp_reg ^ bf_pop;
			fill_next = bf_pop ? 6'(fill_reg + 6'h1) : fill_reg;

			// serializer
			load = tick && (bcnt_reg == SYM_LAST_BIT);
			sym_next = sym_reg;
			bcnt_next = bcnt_reg;
			lvl_next = lvl_reg;
			if (tick) begin
				lvl_next = lvl_reg ^ sym_reg[4];
				sym_next = {sym_reg[3:0], 1'b0};
				bcnt_next = 3'(bcnt_reg + 3'h1);
			end

			// symbol sequencer
			mpend_next = mpend_reg | marker_sync_in[p];
			mact_next = mact_reg;
			st_next = st_reg;
			half_next = half_reg;
			idx_next = idx_reg;
			first_next = first_reg;
			cmdx_next = cmdx_reg;
			prng_next = prng_reg;
			age_next = age_reg;
			cur = st_mem[idx_reg];
			nib = half_reg ? cur[3:0] : cur[7:4];
			if (load) begin
				bcnt_next = 3'h0;
				prng_next = atf_prng4(prng_reg);
				age_next = (age_reg == PRNG_PERIOD) ? age_reg : 10'(age_reg + 10'h1);
				if (mact_reg) begin
					sym_next = atf_enc(CMD_MARKER);
					mact_next = 1'b0;
				end else if (mpend_reg && !half_reg) begin
					sym_next = SYM_ESC;
					mact_next = 1'b1;
					mpend_next = marker_sync_in[p];
				end else begin
					case (st_reg)
						TX_IDLE: begin
							// command bytes start on a byte boundary, where the receiver pairs nibbles
							if (32'(fill_reg) == CELL_BYTES && !half_reg) begin
								sym_next = SYM_ESC;
								st_next = TX_CMD;
								half_next = 1'b1;
								cmdx_next = first_reg || (age_reg == PRNG_PERIOD);
							end else begin
								sym_next = atf_enc(prng_reg[9:6]);
								half_next = ~half_reg;
							end
						end
						TX_CMD: begin
							st_next = TX_DATA;
							half_next = 1'b0;
							idx_next = 6'h00;
							if (cmdx_reg) begin
								sym_next = SYM_ESC;
								prng_next = PRNG_INIT;
								age_next = 10'h000;
								first_next = 1'b0;
							end else begin
								sym_next = atf_enc(CMD_NO_RESET);
							end
						end
						TX_DATA: begin
							sym_next = atf_enc(nib ^ prng_reg[9:6]);
							half_next = ~half_reg;
							if (half_reg) begin
								idx_next = 6'(idx_reg + 6'h1);
								if (32'(idx_reg) == CELL_BYTES - 1) begin
									st_next = TX_IDLE;
									fill_next = 6'h00;
								end
							end
						end
						default: st_next = TX_IDLE;
					endcase
				end
			end
		end

		always_ff @(posedge sys_clk_in) begin
			if (reset_in) begin
				hold_reg <= 8'h00;
				hold_v_reg <= 1'b0;
				bf_wp_reg <= 1'b0;
				bf_rp_reg <= 1'b0;
				bf_cnt_reg <= 2'h0;
				fill_reg <= 6'h00;
				idx_reg <= 6'h00;
				st_reg <= TX_IDLE;
				half_reg <= 1'b0;
				mpend_reg <= 1'b0;
				mact_reg <= 1'b0;
				first_reg <= 1'b1;
				cmdx_reg <= 1'b0;
				prng_reg <= PRNG_INIT;
				age_reg <= 10'h000;
				sym_reg <= SYM_RST;
				bcnt_reg <= 3'h0;
				lvl_reg <= 1'b0;
			end else begin
				hold_reg <= hold_next;
				hold_v_reg <= hold_v_next;
				bf_wp_reg <= bf_wp_next;
				bf_rp_reg <= bf_rp_next;
				bf_cnt_reg <= bf_cnt_next;
				fill_reg <= fill_next;
				idx_reg <= idx_next;
				st_reg <= st_next;
				half_reg <= half_next;
				mpend_reg <= mpend_next;
				mact_reg <= mact_next;
				first_reg <= first_next;
				cmdx_reg <= cmdx_next;
				prng_reg <= prng_next;
				age_reg <= age_next;
				sym_reg <= sym_next;
				bcnt_reg <= bcnt_next;
				lvl_reg <= lvl_next;
			end
		end

		// storage, no reset needed
		always_ff @(posedge sys_clk_in) begin
			if (bf_push) begin
				bf_mem[bf_wp_reg] <= in_d;
			end
			if (bf_pop) begin
				st_mem[fill_reg] <= bf_mem[bf_rp_reg];
			end
		end

		assign port_bus_rdy[p] = brdy;
		assign nib_ready_out[p] = nrdy;
		assign tx_led_out[p] = (st_reg != TX_IDLE);
		assign line.line_lvl[p] = lvl_reg;
	end
endmodule : atf_tx_framer
`default_nettype wire

// ---- atf_pkg.sv ----
// constants, types and line-code functions shared by both ends of the cell framer
`default_nettype none
package atf_pkg;
	// ****************************************
	// sizes and codes
	// ****************************************
	localparam int NUM_PORTS = 3;
	localparam int CELL_BYTES = 53;
	localparam logic [1:0] MODE_BYTE_BUS = 2'h1;
	localparam logic [1:0] MODE_NIBBLE = 2'h2;
	localparam logic [4:0] SYM_ESC = 5'h02;
	// first symbol after reset opens with two ones, so the zeros a fresh
	// receiver holds in its window can never join it into an escape
	localparam logic [4:0] SYM_RST = 5'h1f;
	localparam logic [3:0] CMD_NO_RESET = 4'h4;
	localparam logic [3:0] CMD_MARKER = 4'h8;
	localparam logic [2:0] SYM_LAST_BIT = 3'h4;
	localparam logic [9:0] PRNG_INIT = 10'h3ff;
	localparam logic [9:0] PRNG_PERIOD = 10'h3ff;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_CMD = 2'b01,
		TX_DATA = 2'b10
	} atf_tx_state_e;

	// ****************************************
	// line code
	// ****************************************
	function automatic logic [4:0] atf_enc(input logic [3:0] n);
		case (n)
			4'h0: atf_enc = 5'h15;
			4'h1: atf_enc = 5'h09;
			4'h2: atf_enc = 5'h0a;
			4'h3: atf_enc = 5'h0b;
			4'h4: atf_enc = 5'h07;
			4'h5: atf_enc = 5'h0d;
			4'h6: atf_enc = 5'h0e;
			4'h7: atf_enc = 5'h0f;
			4'h8: atf_enc = 5'h12;
			4'h9: atf_enc = 5'h19;
			4'ha: atf_enc = 5'h1a;
			4'hb: atf_enc = 5'h1b;
			4'hc: atf_enc = 5'h17;
			4'hd: atf_enc = 5'h1d;
			4'he: atf_enc = 5'h1e;
			default: atf_enc = 5'h1f;
		endcase
	endfunction : atf_enc

	// returns {valid, nibble}
	function automatic logic [4:0] atf_dec(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (atf_enc(4'(i)) == s) begin
				r = {1'b1, 4'(i)};
			end
		end
		atf_dec = r;
	endfunction : atf_dec

	// four steps of x^10 + x^7 + 1, one nibble worth
	function automatic logic [9:0] atf_prng4(input logic [9:0] s);
		logic [9:0] t;
		t = s;
		for (int i = 0; i < 4; i++) begin
			t = {t[8:0], t[9] ^ t[6]};
		end
		atf_prng4 = t;
	endfunction : atf_prng4
endpackage : atf_pkg
`default_nettype wire

// ---- atf_line_if.sv ----
// serial line between the framer and the remote receiver
`timescale 1ns/1ps
`default_nettype none
interface atf_line_if #(parameter int NPORT = atf_pkg::NUM_PORTS);
	logic [NPORT-1:0] line_lvl;
	logic bit_tick;
	modport dev (output line_lvl, output bit_tick);
	modport far (input line_lvl, input bit_tick);
endinterface : atf_line_if
`default_nettype wire

// ---- atf_rx_deframer.sv ----
// remote receiver: NRZI decode, symbol lock, command bytes, descrambler
`timescale 1ns/1ps
`default_nettype none
module atf_rx_deframer #(
	parameter int NPORT = atf_pkg::NUM_PORTS
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// line side
	atf_line_if.far line,
	// cell output
	output wire logic [8*NPORT-1:0] cell_byte_out,
	output wire logic [NPORT-1:0] cell_valid_out,
	output wire logic [NPORT-1:0] cell_first_out,
	// marker extract and status
	output wire logic [NPORT-1:0] marker_out,
	output wire logic [NPORT-1:0] rx_led_out
);
	import atf_pkg::*;

	if (NPORT < 1 || NPORT > 4) begin : g_bad_nport
		$error("NPORT must be 1 to 4");
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic prev_reg, prev_next, sync_reg, sync_next, lo_reg, lo_next, esc_reg, esc_next;
		logic [4:0] sr_reg, sr_next, win, d;
		logic [2:0] bc_reg, bc_next;
		logic [3:0] hin_reg, hin_next;
		logic [9:0] prng_reg, prng_next;
		logic [5:0] left_reg, left_next;
		logic [7:0] byte_reg, byte_next;
		logic bval_reg, bval_next, bfirst_reg, bfirst_next, pfirst_reg, pfirst_next, mark_reg, mark_next;
		logic done;

		always_comb begin
			prev_next = prev_reg;
			sr_next = sr_reg;
			sync_next = sync_reg;
			bc_next = bc_reg;
			lo_next = lo_reg;
			esc_next = esc_reg;
			hin_next = hin_reg;
			prng_next = prng_reg;
			left_next = left_reg;
			byte_next = byte_reg;
			bval_next = 1'b0;
			bfirst_next = 1'b0;
			pfirst_next = pfirst_reg;
			mark_next = 1'b0;
			win = {sr_reg[3:0], line.line_lvl[p] ^ prev_reg};
			d = atf_dec(win);
			done = 1'b0;
			if (line.bit_tick) begin
				prev_next = line.line_lvl[p];
				sr_next = win;
				if (!sync_reg) begin
					if (win == SYM_ESC) begin
						sync_next = 1'b1;
						done = 1'b1;
						bc_next = 3'h0;
					end
				end else if (bc_reg == SYM_LAST_BIT) begin
					done = 1'b1;
					bc_next = 3'h0;
				end else begin
					bc_next = 3'(bc_reg + 3'h1);
				end
			end
			if (done) begin
				prng_next = atf_prng4(prng_reg);
				if (!lo_reg) begin
					lo_next = 1'b1;
					esc_next = (win == SYM_ESC);
					hin_next = d[3:0] ^ prng_reg[9:6];
				end else begin
					lo_next = 1'b0;
					if (esc_reg) begin
						if (win == SYM_ESC) begin
							prng_next = PRNG_INIT;
							left_next = 6'(CELL_BYTES);
							pfirst_next = 1'b1;
						end else if (d[3:0] == CMD_NO_RESET) begin
							left_next = 6'(CELL_BYTES);
							pfirst_next = 1'b1;
						end else if (d[3:0] == CMD_MARKER) begin
							mark_next = 1'b1;
						end
					end else if (left_reg != 6'h00) begin
						byte_next = {hin_reg, d[3:0] ^ prng_reg[9:6]};
						bval_next = 1'b1;
						bfirst_next = pfirst_reg;
						pfirst_next = 1'b0;
						left_next = 6'(left_reg - 6'h1);
					end
				end
			end
		end

		always_ff @(posedge sys_clk_in) begin
			if (reset_in) begin
				prev_reg <= 1'b0;
				sr_reg <= 5'h00;
				sync_reg <= 1'b0;
				bc_reg <= 3'h0;
				lo_reg <= 1'b0;
				esc_reg <= 1'b0;
				hin_reg <= 4'h0;
				prng_reg <= PRNG_INIT;
				left_reg <= 6'h00;
				byte_reg <= 8'h00;
				bval_reg <= 1'b0;
				bfirst_reg <= 1'b0;
				pfirst_reg <= 1'b0;
				mark_reg <= 1'b0;
			end else begin
				prev_reg <= prev_next;
				sr_reg <= sr_next;
				sync_reg <= sync_next;
				bc_reg <= bc_next;
				lo_reg <= lo_next;
				esc_reg <= esc_next;
				hin_reg <= hin_next;
				prng_reg <= prng_next;
				left_reg <= left_next;
				byte_reg <= byte_next;
				bval_reg <= bval_next;
				bfirst_reg <= bfirst_next;
				pfirst_reg <= pfirst_next;
				mark_reg <= mark_next;
			end
		end

		assign cell_byte_out[8*p +: 8] = byte_reg;
		assign cell_valid_out[p] = bval_reg;
		assign cell_first_out[p] = bfirst_reg;
		assign marker_out[p] = mark_reg;
		assign rx_led_out[p] = sync_reg;
	end
endmodule : atf_rx_deframer
`default_nettype wire

// ---- atf_monitor.sv ----
// line checker between the framer and the deframer
`timescale 1ns/1ps
`default_nettype none
module atf_monitor import atf_pkg::*; (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// serial line
	input wire logic [NUM_PORTS-1:0] line_lvl,
	input wire logic bit_tick
);
	// ****************************************
	// zero-bit run per port
	// ****************************************
	logic tick_reg;
	logic [NUM_PORTS-1:0] lvl_reg;
	logic [2:0] zrun_reg [NUM_PORTS];
	logic [2:0] zrun_next [NUM_PORTS];
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			zrun_next[p] = zrun_reg[p];
			if (tick_reg) begin
				zrun_next[p] = (line_lvl[p] != lvl_reg[p]) ? 3'h0 : zrun_reg[p] + 3'h1;
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			tick_reg <= 1'b0;
			lvl_reg <= '0;
			zrun_reg <= '{default: 3'h0};
		end else begin
			tick_reg <= bit_tick;
			lvl_reg <= line_lvl;
			zrun_reg <= zrun_next;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	lvl0_tick_a: assert property ($changed(line_lvl[0]) |-> $past(bit_tick)) else $error("line 0 moved off tick");
	lvl1_tick_a: assert property ($changed(line_lvl[1]) |-> $past(bit_tick)) else $error("line 1 moved off tick");
	lvl2_tick_a: assert property ($changed(line_lvl[2]) |-> $past(bit_tick)) else $error("line 2 moved off tick");
	zero_run0_a: assert property (zrun_reg[0] <= 3'h5) else $error("line 0 zero run too long");
	zero_run1_a: assert property (zrun_reg[1] <= 3'h5) else $error("line 1 zero run too long");
	zero_run2_a: assert property (zrun_reg[2] <= 3'h5) else $error("line 2 zero run too long");
	tick_pace_a: assert property (!bit_tick |=> bit_tick) else $error("bit tick gap too long");
	reset_idle_a: assert property ($fell(reset_in) |-> line_lvl == '0) else $error("line not idle at reset");
	cover property (bit_tick [*3]);
	cover property (zrun_reg[0] == 3'h4);
	cover property ($changed(line_lvl[2]));
endmodule : atf_monitor
`default_nettype wire

// ---- atm25_tc_cell_framer_tb.sv ----
// bench: framer to deframer over the line interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module atm25_tc_cell_framer_tb;
	import atf_pkg::*;
	// ****************************************
	// wiring
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mode = MODE_BYTE_BUS;
	logic rate = 1'b0;
	logic [15:0] bd = '0;
	logic [1:0] bp = '0;
	logic bv = 1'b0;
	logic [11:0] nd = '0;
	logic [2:0] nv = '0;
	logic [2:0] ms = '0;
	wire logic br;
	wire logic [2:0] nr, tled, cv, first, mk, rled;
	wire logic [23:0] cb;
	int fails = 0;
	int n_tests = 0;
	int n_first [3];
	int n_mark [3];
	logic [7:0] exp_q [3][$];
	atf_line_if atf_line_if_i ();
	atf_tx_framer atf_tx_framer_i (.sys_clk_in(clk), .reset_in(rst), .mode_sel_in(mode), .rate_double_in(rate),
		.bus_data_in(bd), .bus_port_in(bp), .bus_valid_in(bv), .bus_ready_out(br), .nib_data_in(nd),
		.nib_valid_in(nv), .nib_ready_out(nr), .marker_sync_in(ms), .tx_led_out(tled), .line(atf_line_if_i.dev));
	atf_rx_deframer atf_rx_deframer_i (.sys_clk_in(clk), .reset_in(rst), .line(atf_line_if_i.far),
		.cell_byte_out(cb), .cell_valid_out(cv), .cell_first_out(first), .marker_out(mk), .rx_led_out(rled));
	atf_monitor atf_monitor_i (.sys_clk_in(clk), .reset_in(rst), .line_lvl(atf_line_if_i.line_lvl),
		.bit_tick(atf_line_if_i.bit_tick));
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		logic [7:0] e;
		for (int p = 0; p < 3; p++) begin
			if (cv[p] === 1'b1) begin
				e = exp_q[p].pop_front();
				`CHK(cb[8*p+:8], e)
			end
			if (first[p] === 1'b1) n_first[p]++;
			if (mk[p] === 1'b1) n_mark[p]++;
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic report_and_stop;
		if (fails == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input logic [1:0] m, input logic r);
		rst <= 1'b1;
		mode <= m;
		rate <= r;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		n_first = '{default: 0};
		n_mark = '{default: 0};
	endtask : do_reset
	task automatic put(input int p, input int nbytes, input int base);
		logic [7:0] b;
		logic [15:0] w;
		int k;
		w = '0;
		for (int i = 0; i < nbytes; i++) begin
			b = 8'(base + i * 7);
			w = {w[7:0], b};
			k = 0;
			exp_q[p].push_back(b);
			if (mode == MODE_NIBBLE) begin
				for (int h = 1; h >= 0; h--) begin
					nd[4*p+:4] <= b[4*h+:4];
					nv[p] <= 1'b1;
					do begin @(posedge clk); k++; end while (nr[p] !== 1'b1 && k < 9999);
				end
			end else if (mode == MODE_BYTE_BUS || i % 2 == 1) begin
				bd <= w;
				bp <= 2'(p);
				bv <= 1'b1;
				do begin @(posedge clk); k++; end while (br !== 1'b1 && k < 9999);
			end
			if (k >= 9999) fails++;
		end
		if (mode == MODE_NIBBLE) nv[p] <= 1'b0;
		else bv <= 1'b0;
	endtask : put
	task automatic drain;
		int k;
		k = 0;
		while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() != 0 && k < 20000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 20000) fails++;
		repeat (40) @(posedge clk);
	endtask : drain
	// ****************************************
	// tests
	// ****************************************
	initial begin
		do_reset(MODE_BYTE_BUS, 1'b0);
		bp <= 2'h3;
		bv <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		`CHK(br, 1'b0)
		bv <= 1'b0;
		ms[2] <= 1'b1;
		@(posedge clk);
		ms[2] <= 1'b0;
		put(0, 106, 1);
		fork
			put(1, 53, 9);
			begin
				repeat (300) @(posedge clk);
				ms[0] <= 1'b1;
				@(posedge clk);
				ms[0] <= 1'b0;
			end
		join
		drain;
		`CHK(n_first[0], 2)
		`CHK(n_first[1], 1)
		`CHK(n_mark[0], 1)
		`CHK(n_mark[2], 1)
		`CHK(rled, 3'h7)
		do_reset(2'h0, 1'b1);
		put(2, 106, 3);
		drain;
		`CHK(n_first[2], 2)
		do_reset(MODE_NIBBLE, 1'b1);
		bp <= 2'h0;
		bv <= 1'b1;
		@(posedge clk);
		`CHK(br, 1'b0)
		bv <= 1'b0;
		fork
			put(0, 53, 5);
			put(1, 53, 6);
			put(2, 53, 7);
		join
		drain;
		for (int p = 0; p < 3; p++) `CHK(n_first[p], 1)
		`CHK(tled, 3'h0)
		report_and_stop;
	end
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		report_and_stop;
	end
endmodule : atm25_tc_cell_framer_tb
`default_nettype wire
